//--- hdl/jet_drop_timing_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module jet_drop_timing_sequencer
  import jet_seq_pkg::*;
#(
  parameter int STEPS_PER_SEC = STEPS_PER_SEC_DEF
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]      avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // trigger inputs, active low
  input  wire logic [NUM_RECIPES-1:0] trig_n,
  // jet drive and status
  output logic                        jet_activity_flag,
  output logic                        refill_phase,
  output logic                        dwell_phase,
  output logic                        drop_done
);

  typedef struct packed {
    logic                                 resp;
    logic [31:0]                          rdata;
    logic [NUM_RECIPES-1:0][TIME_W-1:0]   refill;
    logic [NUM_RECIPES-1:0][TIME_W-1:0]   dwell;
    logic [NUM_RECIPES-1:0][3:0][TIME_W-1:0] rsv;
    logic [NUM_RECIPES-1:0][TIME_W-1:0]   plus;
    logic [NUM_RECIPES-1:0][TIME_W-1:0]   pp;
    logic [NUM_RECIPES-1:0][TIME_W-1:0]   thr;
    logic [NUM_RECIPES-1:0][TIME_W-1:0]   count;
    logic [NUM_RECIPES-1:0]               style;
    seq_state_t                           fsm;
    logic [NUM_RECIPES-1:0]               trig_q;
    logic [RECIPE_W-1:0]                  cur;
    logic [TIME_W-1:0]                    remaining;
    logic                                 first;
    logic                                 idle_long;
    logic [DIV_W-1:0]                     div;
    logic [PHASE_W-1:0]                   rem;
    logic [DIV_W-1:0]                     free_div;
    logic [TIME_W-1:0]                    sec_div;
    logic [TIME_W-1:0]                    idle_sec;
    logic                                 done;
    logic [PHASE_W-1:0]                   len_ld;
    logic [31:0]                          ph_cyc;
  } state_t;

  state_t s;
  state_t next_s;

  localparam logic [DIV_W-1:0]  STEP_LAST = DIV_W'(STEP_CYCLES - 1);
  localparam logic [TIME_W-1:0] SEC_LAST  = TIME_W'(STEPS_PER_SEC - 1);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  // extensions only ever add to refill
  function automatic logic [PHASE_W-1:0] refill_len(input logic [TIME_W-1:0] base,
                                                    input logic [TIME_W-1:0] plus,
                                                    input logic [TIME_W-1:0] pp,
                                                    input logic              line,
                                                    input logic              first,
                                                    input logic              idle_long);
    logic [PHASE_W-1:0] len;
    len = PHASE_W'(base);
    if (!line || first)
      len = len + PHASE_W'(plus);
    if (first && idle_long)
      len = len + PHASE_W'(pp);
    return len;
  endfunction : refill_len

  // single-drop style is a pulse recipe with a count of one
  function automatic logic is_line(input logic style, input logic [TIME_W-1:0] cnt);
    return (style == STYLE_LEVEL) || (cnt > TIME_W'(1));
  endfunction : is_line

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [RECIPE_W-1:0]    idx;
  logic [4:0]             ofs;
  logic [31:0]            rd;
  logic [31:0]            wm;
  logic [NUM_RECIPES-1:0] fall;
  logic                   phase_end;
  logic                   go_on;

  always_comb
  begin
    next_s    = s;
    idx       = avs_address[7:5];
    ofs       = avs_address[4:0];
    rd        = 32'h0000_0000;
    wm        = 32'h0000_0000;
    fall      = s.trig_q & ~trig_n;
    phase_end = 1'b0;
    go_on     = 1'b0;
    next_s.done   = 1'b0;
    next_s.trig_q = trig_n;

    // bus: one wait cycle, answer on the second edge
    next_s.resp = (avs_read || avs_write) && !s.resp;
    if (idx < RECIPE_W'(NUM_RECIPES))
    begin
      unique case (ofs)
        OFS_REFILL: rd = {16'h0000, s.refill[idx]};
        OFS_DWELL:  rd = {16'h0000, s.dwell[idx]};
        OFS_RSV_LO: rd = {s.rsv[idx][1], s.rsv[idx][0]};
        OFS_RSV_HI: rd = {s.rsv[idx][3], s.rsv[idx][2]};
        OFS_EXT:    rd = {s.pp[idx], s.plus[idx]};
        OFS_IDLE:   rd = {16'h0000, s.thr[idx]};
        OFS_CTRL:   rd = {15'h0000, s.style[idx], s.count[idx]};
        default:    rd = 32'h0000_0000;
      endcase
    end
    else if (avs_address == STATUS_ADDR)
    begin
      rd[STAT_FLAG_BIT] = (s.fsm == SEQ_IDLE);
      rd[STAT_RECIPE_LSB +: RECIPE_W] = s.cur;
      rd[STAT_IDLE_LSB +: TIME_W] = s.idle_sec;
    end
    if (avs_read && !s.resp)
      next_s.rdata = rd;
    wm = merge(rd, avs_writedata, avs_byteenable);
    if (avs_write && s.resp && idx < RECIPE_W'(NUM_RECIPES))
    begin
      unique case (ofs)
        OFS_REFILL: next_s.refill[idx] = wm[15:0];
        OFS_DWELL:  next_s.dwell[idx]  = wm[15:0];
        OFS_RSV_LO: next_s.rsv[idx][1:0] = wm;
        OFS_RSV_HI: next_s.rsv[idx][3:2] = wm;
        OFS_EXT:    {next_s.pp[idx], next_s.plus[idx]} = wm;
        OFS_IDLE:   next_s.thr[idx] = wm[15:0];
        OFS_CTRL:
        begin
          next_s.count[idx] = wm[15:0];
          next_s.style[idx] = wm[CTRL_STYLE_BIT];
        end
        default: ;
      endcase
    end

    // idle time in whole seconds, saturating
    next_s.free_div = (s.free_div == STEP_LAST) ? '0 : s.free_div + DIV_W'(1);
    if (s.free_div == STEP_LAST)
    begin
      next_s.sec_div = (s.sec_div == SEC_LAST) ? '0 : s.sec_div + TIME_W'(1);
      if (s.sec_div == SEC_LAST && s.idle_sec != '1)
        next_s.idle_sec = s.idle_sec + TIME_W'(1);
    end

    // phase timer: exactly rem steps, a zero phase takes one cycle
    next_s.ph_cyc = s.ph_cyc + 32'h0000_0001;
    if (s.fsm != SEQ_IDLE)
    begin
      if (s.rem == '0 || (s.div == STEP_LAST && s.rem == PHASE_W'(1)))
        phase_end = 1'b1;
      else if (s.div == STEP_LAST)
      begin
        next_s.div = '0;
        next_s.rem = s.rem - PHASE_W'(1);
      end
      else
        next_s.div = s.div + DIV_W'(1);
    end

    unique case (s.fsm)
      SEQ_IDLE:
      begin
        // lowest index wins when several inputs fire together
        for (int r = NUM_RECIPES - 1; r >= 0; r--)
        begin
          if ((s.style[r] == STYLE_LEVEL) ? !trig_n[r]
              : (fall[r] && s.count[r] != '0))
          begin
            next_s.cur       = RECIPE_W'(r);
            next_s.first     = 1'b1;
            next_s.idle_long = s.idle_sec > s.thr[r];
            next_s.remaining = s.count[r];
            next_s.fsm       = SEQ_REFILL;
            next_s.div       = '0;
            next_s.ph_cyc    = '0;
            next_s.rem       = refill_len(s.refill[r], s.plus[r], s.pp[r],
                                          is_line(s.style[r], s.count[r]), 1'b1,
                                          s.idle_sec > s.thr[r]);
            next_s.len_ld    = next_s.rem;
          end
        end
      end
      SEQ_REFILL:
      begin
        if (phase_end)
        begin
          next_s.fsm    = SEQ_DWELL;
          next_s.div    = '0;
          next_s.ph_cyc = '0;
          next_s.rem    = PHASE_W'(s.dwell[s.cur]);
          next_s.len_ld = next_s.rem;
        end
      end
      SEQ_DWELL:
      begin
        if (phase_end)
        begin
          next_s.done     = 1'b1;
          next_s.first    = 1'b0;
          next_s.idle_sec = '0;
          next_s.sec_div  = '0;
          if (s.style[s.cur] == STYLE_LEVEL)
            go_on = !trig_n[s.cur];
          else
            go_on = s.remaining > TIME_W'(1);
          next_s.remaining = s.remaining - TIME_W'(1);
          next_s.fsm    = go_on ? SEQ_REFILL : SEQ_IDLE;
          next_s.div    = '0;
          next_s.ph_cyc = '0;
          next_s.rem    = refill_len(s.refill[s.cur], s.plus[s.cur], s.pp[s.cur],
                                     is_line(s.style[s.cur], s.count[s.cur]),
                                     1'b0, 1'b0);
          next_s.len_ld = next_s.rem;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s        <= '0;
      s.fsm    <= SEQ_IDLE;
      s.trig_q <= '1;
      s.style  <= {NUM_RECIPES{STYLE_RST}};
      s.rsv    <= {(NUM_RECIPES * 4){TIME_RST}};
    end
    else
      s <= next_s;
  end

  assign avs_readdata      = s.rdata;
  assign avs_waitrequest   = (avs_read || avs_write) && !s.resp;
  assign jet_activity_flag = (s.fsm == SEQ_IDLE);
  assign refill_phase      = (s.fsm == SEQ_REFILL);
  assign dwell_phase       = (s.fsm == SEQ_DWELL);
  assign drop_done         = s.done;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  start_on_trigger_a: assert property (
    $fell(jet_activity_flag) |-> $past(!(&trig_n)))
    else $error("dispense started without a low trigger");

  refill_before_dwell_a: assert property (
    $rose(dwell_phase) |-> $past(refill_phase))
    else $error("dwell entered without refill");

  dwell_length_a: assert property (
    (dwell_phase && phase_end && s.len_ld != '0)
      |-> (s.ph_cyc + 32'h0000_0001 == 32'(s.len_ld) * STEP_CYCLES))
    else $error("phase length wrong");

  refill_length_a: assert property (
    (refill_phase && phase_end && s.len_ld != '0)
      |-> (s.ph_cyc + 32'h0000_0001 == 32'(s.len_ld) * STEP_CYCLES))
    else $error("refill length wrong");

  line_plain_refill_a: assert property (
    ($rose(refill_phase) || (refill_phase && $past(dwell_phase))) && !s.first
      && is_line(s.style[s.cur], s.count[s.cur])
      |-> s.len_ld == PHASE_W'(s.refill[s.cur]))
    else $error("line drop after first got an extension");

  ignore_busy_a: assert property (
    !jet_activity_flag |=> s.cur == $past(s.cur))
    else $error("recipe changed during a cycle");

  level_stop_a: assert property (
    (dwell_phase && phase_end && s.style[s.cur] == STYLE_LEVEL && trig_n[s.cur])
      |=> jet_activity_flag)
    else $error("level recipe kept firing after release");

  burst_next_a: assert property (
    (dwell_phase && phase_end && s.style[s.cur] == STYLE_PULSE
      && s.remaining > TIME_W'(1)) |=> refill_phase)
    else $error("burst ended early");

  idle_clear_a: assert property (
    drop_done |-> s.idle_sec == '0)
    else $error("idle time not cleared on drop");

  single_plus_a: assert property (
    $rose(refill_phase) && !is_line(s.style[s.cur], s.count[s.cur])
      |-> s.len_ld == PHASE_W'(s.refill[s.cur]) + PHASE_W'(s.plus[s.cur])
        + (s.idle_long ? PHASE_W'(s.pp[s.cur]) : PHASE_W'(0)))
    else $error("single drop refill missing its extension");

  dwell_plain_a: assert property (
    $rose(dwell_phase) |-> s.len_ld == PHASE_W'(s.dwell[s.cur]))
    else $error("dwell got an extension");

endmodule : jet_drop_timing_sequencer

`default_nettype wire

//--- include/jet_seq_pkg.sv
package jet_seq_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_RECIPES = 6;
  localparam int RECIPE_W    = 3;
  localparam int TIME_W      = 16;
  localparam int PHASE_W     = 18;
  localparam int DIV_W       = 12;
  localparam int ADDR_W      = 8;

  // ---------------------------------------------------------------
  // timing: one step is 0.1 ms
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 25;
  localparam int STEP_TIME_NS      = 100000;
  localparam int STEP_CYCLES       = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int STEPS_PER_SEC_DEF = 10000;

  // ---------------------------------------------------------------
  // register map: recipe r at byte address r * 0x20 + offset
  // ---------------------------------------------------------------
  localparam logic [4:0]        OFS_REFILL  = 5'h00;
  localparam logic [4:0]        OFS_DWELL   = 5'h04;
  localparam logic [4:0]        OFS_RSV_LO  = 5'h08;
  localparam logic [4:0]        OFS_RSV_HI  = 5'h0C;
  localparam logic [4:0]        OFS_EXT     = 5'h10;
  localparam logic [4:0]        OFS_IDLE    = 5'h14;
  localparam logic [4:0]        OFS_CTRL    = 5'h18;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'hC0;

  // field positions
  localparam int EXT_PP_LSB      = 16;
  localparam int CTRL_STYLE_BIT  = 16;
  localparam int STAT_FLAG_BIT   = 0;
  localparam int STAT_RECIPE_LSB = 4;
  localparam int STAT_IDLE_LSB   = 16;

  // reset values
  localparam logic [TIME_W-1:0] TIME_RST  = 16'h0000;
  localparam logic              STYLE_RST = 1'b0;

  // trigger_style encoding
  localparam logic STYLE_PULSE = 1'b0;
  localparam logic STYLE_LEVEL = 1'b1;

  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'b001,
    SEQ_REFILL = 3'b010,
    SEQ_DWELL  = 3'b100
  } seq_state_t;

endpackage : jet_seq_pkg

//--- tb/robot_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// motion controller driving the trigger pins
// ---------------------------------------------------------------
module robot_model
  import jet_seq_pkg::*;
(
  // clock and status
  input  wire logic                   clk_sys,
  input  wire logic                   jet_activity_flag,
  // triggers, active low
  output var  logic [NUM_RECIPES-1:0] trig_n
);

  initial trig_n = '1;

  // short low pulse; polite waits for the jet to go idle first
  task automatic pulse(input int r, input bit polite);
    if (polite)
      while (jet_activity_flag !== 1'b1) @(posedge clk_sys);
    @(posedge clk_sys);
    trig_n[r] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    trig_n[r] <= 1'b1;
  endtask : pulse

  task automatic level(input int r, input logic low);
    @(posedge clk_sys);
    trig_n[r] <= ~low;
  endtask : level

endmodule : robot_model

`default_nettype wire

//--- tb/test_jet_drop_timing_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module test_jet_drop_timing_sequencer;
  import jet_seq_pkg::*;

  logic                   clk_sys;
  logic                   reset_n;
  logic [ADDR_W-1:0]      avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic [NUM_RECIPES-1:0] trig_n;
  logic                   jet_activity_flag;
  logic                   refill_phase;
  logic                   dwell_phase;
  logic                   drop_done;
  logic [31:0]            lens[$];
  logic [31:0]            dwells[$];
  int                     dwell_run;
  logic [31:0]            d;
  int                     run;
  int                     drops;
  int                     bad_count;
  int                     n_checks;

  // all scenarios together take about 65000 cycles
  localparam int WATCHDOG_CYCLES = 90000;

  jet_drop_timing_sequencer #(.STEPS_PER_SEC(2)) i_jet_drop_timing_sequencer (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_n(trig_n),
    .jet_activity_flag(jet_activity_flag), .refill_phase(refill_phase),
    .dwell_phase(dwell_phase), .drop_done(drop_done));

  robot_model i_robot_model (
    .clk_sys(clk_sys), .jet_activity_flag(jet_activity_flag), .trig_n(trig_n));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // monitor: refill lengths in cycles, completed drops
  // ---------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (refill_phase === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      lens.push_back(run);
      run <= 0;
    end
    if (dwell_phase === 1'b1)
      dwell_run <= dwell_run + 1;
    else if (dwell_run != 0)
    begin
      dwells.push_back(dwell_run);
      dwell_run <= 0;
    end
    if (drop_done === 1'b1)
      drops <= drops + 1;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    avs_write     <= 1'b1;
    avs_address   <= a;
    avs_writedata <= v;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    avs_read    <= 1'b1;
    avs_address <= a;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask : rd

  task automatic set_recipe(input logic [2:0] r, input logic [15:0] refill, dwell, plus, ext,
                            input logic [15:0] count, input logic style);
    wr({r, OFS_REFILL}, {16'h0000, refill});
    wr({r, OFS_DWELL}, {16'h0000, dwell});
    wr({r, OFS_EXT}, {ext, plus});
    wr({r, OFS_IDLE}, 32'h0000_0000);
    wr({r, OFS_CTRL}, {15'h0000, style, count});
  endtask : set_recipe

  task automatic wait_done();
    int n;
    n = 0;
    while (jet_activity_flag !== 1'b0 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    while (jet_activity_flag !== 1'b1) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
  endtask : wait_done

  task automatic clear_mon();
    lens.delete();
    dwells.delete();
    drops = 0;
  endtask : clear_mon

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd({3'd0, OFS_RSV_LO}, d);
    check(d, 32'h0000_0000);
    rd({3'd0, OFS_RSV_HI}, d);
    check(d, 32'h0000_0000);
    rd({3'd0, OFS_CTRL}, d);
    check(d, 32'h0000_0000);
    rd(STATUS_ADDR, d);
    check({31'h0, d[STAT_FLAG_BIT]}, 32'h0000_0001);
    wr(8'hE0, 32'h0000_5A5A);
    rd(8'hE0, d);
    check(d, 32'h0000_0000);
    wr({3'd5, OFS_DWELL}, 32'h0000_1234);
    rd({3'd5, OFS_DWELL}, d);
    check(d, 32'h0000_1234);
  endtask : t_regs

  task automatic t_line_pulse();
    set_recipe(3'd0, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0002, STYLE_PULSE);
    clear_mon();
    i_robot_model.pulse(0, 1'b1);
    wait_done();
    check(drops, 32'h0000_0002);
    check(lens.size(), 32'h0000_0002);
    check(lens[0], 2 * STEP_CYCLES);
    check(lens[1], STEP_CYCLES);
    check(dwells.size(), 32'h0000_0002);
    check(dwells[0], STEP_CYCLES);
    check(dwells[1], STEP_CYCLES);
  endtask : t_line_pulse

  task automatic t_single();
    set_recipe(3'd1, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, STYLE_PULSE);
    wr({3'd1, OFS_RSV_LO}, 32'hFFFF_FFFF);
    wr({3'd1, OFS_RSV_HI}, 32'hFFFF_FFFF);
    rd({3'd1, OFS_RSV_HI}, d);
    check(d, 32'hFFFF_FFFF);
    clear_mon();
    i_robot_model.pulse(1, 1'b1);
    i_robot_model.pulse(0, 1'b0);
    wait_done();
    check(drops, 32'h0000_0001);
    i_robot_model.pulse(1, 1'b1);
    wait_done();
    check(drops, 32'h0000_0002);
    check(lens[0], STEP_CYCLES);
    check(lens[1], STEP_CYCLES);
  endtask : t_single

  task automatic t_level();
    set_recipe(3'd2, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0005, STYLE_LEVEL);
    clear_mon();
    i_robot_model.level(2, 1'b1);
    while (!(lens.size() == 2 && refill_phase === 1'b1)) @(posedge clk_sys);
    i_robot_model.level(2, 1'b0);
    wait_done();
    check(drops, 32'h0000_0003);
    check(lens[2], STEP_CYCLES);
  endtask : t_level

  task automatic t_idle();
    set_recipe(3'd3, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, STYLE_PULSE);
    repeat (5 * STEP_CYCLES) @(posedge clk_sys);
    clear_mon();
    i_robot_model.pulse(3, 1'b1);
    wait_done();
    i_robot_model.pulse(3, 1'b1);
    wait_done();
    check(lens[0], STEP_CYCLES);
    check(lens[1], 32'h0000_0001);
    rd(STATUS_ADDR, d);
    check(d[STAT_RECIPE_LSB +: RECIPE_W], 32'h0000_0003);
    check(d[STAT_IDLE_LSB +: TIME_W], 32'h0000_0000);
  endtask : t_idle

  task automatic close_out();
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (WATCHDOG_CYCLES) @(posedge clk_sys);
    bad_count++;
    close_out();
  end

  initial
  begin
    reset_n       = 1'b0;
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
    run           = 0;
    dwell_run     = 0;
    drops         = 0;
    bad_count     = 0;
    n_checks      = 0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_line_pulse();
    t_single();
    t_level();
    t_idle();
    close_out();
  end

endmodule : test_jet_drop_timing_sequencer

`default_nettype wire
